// file: include/adcac_pkg.sv
package adcac_pkg;

  // register offsets (byte addresses on the host i/o bus)
  localparam logic [3:0] ADCAC_OFF_CNT0 = 4'h0;
  localparam logic [3:0] ADCAC_OFF_CNT1 = 4'h1;
  localparam logic [3:0] ADCAC_OFF_CNT2 = 4'h2;
  localparam logic [3:0] ADCAC_OFF_DATA_LO = 4'h4;
  localparam logic [3:0] ADCAC_OFF_DATA_HI = 4'h5;
  localparam logic [3:0] ADCAC_OFF_INT_CLR = 4'h8;
  localparam logic [3:0] ADCAC_OFF_GAIN = 4'h9;
  localparam logic [3:0] ADCAC_OFF_CHAN = 4'hA;
  localparam logic [3:0] ADCAC_OFF_MODE = 4'hB;
  localparam logic [3:0] ADCAC_OFF_STROBE = 4'hC;
  localparam logic [3:0] ADCAC_OFF_DO_LO = 4'hD;
  localparam logic [3:0] ADCAC_OFF_DO_HI = 4'hE;

  // mode register fields
  localparam int ADCAC_MODE_LSB = 0;
  localparam int ADCAC_IRQ_LSB = 4;
  localparam logic [2:0] ADCAC_MODE_SW0 = 3'h0;
  localparam logic [2:0] ADCAC_MODE_SW1 = 3'h1;
  localparam logic [2:0] ADCAC_MODE_PACER = 3'h2;
  localparam logic [2:0] ADCAC_MODE_PACER_INT = 3'h6;

  // irq line codes
  localparam logic [2:0] ADCAC_IRQ_UNUSED = 3'h1;
  localparam logic [2:0] ADCAC_IRQ2_ALT = 3'h2;
  localparam logic [2:0] ADCAC_IRQ_BASE = 3'h3;
  localparam int ADCAC_IRQ_LINES = 6;

  // reset values
  localparam logic [7:0] ADCAC_BYTE_RST = 8'h00;
  localparam logic [15:0] ADCAC_CNT_RST = 16'hFFFF;
  localparam logic [15:0] ADCAC_CNT_ONE = 16'h0001;
  localparam logic [15:0] ADCAC_CNT_ZERO = 16'h0000;
  localparam logic [7:0] ADCAC_RDY_BIT = 8'h10;

  // gain factors per code (low and high variants)
  localparam logic [10:0] ADCAC_GAIN_LO [4] = '{11'd1, 11'd2, 11'd4, 11'd8};
  localparam logic [10:0] ADCAC_GAIN_HI [4] = '{11'd1, 11'd10, 11'd100, 11'd1000};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } adcac_bus_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic [15:0] dout;
  } adcac_host_out_type;

endpackage

// file: src/adcac_pacer.sv
module adcac_pacer
  import adcac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // reload control
  input wire logic load_lo,
  input wire logic load_hi,
  input wire logic [7:0] load_data,
  input wire logic run,
  // periodic tick
  output logic tick
);
  import adcac_pkg::*;

  typedef struct packed {
    logic [15:0] div1;
    logic [15:0] div2;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic tick;
  } adcac_pacer_type;

  adcac_pacer_type s_r;
  adcac_pacer_type s_nxt;

  assign tick = s_r.tick;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (load_lo) begin
      s_nxt.div1 = {s_r.div1[7:0], load_data};
    end
    if (load_hi) begin
      s_nxt.div2 = {s_r.div2[7:0], load_data};
    end
    if (!run) begin
      s_nxt.cnt1 = s_nxt.div1;
      s_nxt.cnt2 = s_nxt.div2;
    end else if (s_r.cnt1 <= ADCAC_CNT_ONE) begin
      s_nxt.cnt1 = s_r.div1;
      if (s_r.cnt2 <= ADCAC_CNT_ONE) begin
        s_nxt.cnt2 = s_r.div2;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt2 = s_r.cnt2 - ADCAC_CNT_ONE;
      end
    end else begin
      s_nxt.cnt1 = s_r.cnt1 - ADCAC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{div1: ADCAC_CNT_RST, div2: ADCAC_CNT_RST, cnt1: ADCAC_CNT_RST,
               cnt2: ADCAC_CNT_RST, tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // adcac_pacer

// file: src/adcac_top.sv
// Summary of operation
// - two-bit gain code selects four gain steps
// - single-ended uses low four channel bits
// - differential uses low three bits, pairs
// - modes 000/001 software trigger, polled only
// - mode 110 pacer trigger, polled and interrupt
// - bits 6:4 route interrupt to bus line
// - strobe write fires one conversion in modes 000/001 only
// - high data byte shows busy flag in bit 4, one until result ready
// - interrupt mode raises request per completion
// - counters one and two chain to 32 bits
// - pacer output triggers converter in pacer modes
// - two byte latches drive sixteen outputs
// - ready reads one until result ready
// - interrupt flag set per conversion in mode 110, write clears
module adcac_top
  import adcac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host register bus
  input wire adcac_pkg::adcac_bus_type bus,
  output adcac_pkg::adcac_host_out_type host_out,
  // board straps and converter
  input wire logic input_type_jumper,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic adc_trigger,
  // analog front end
  output logic [3:0] mux_sel,
  output logic mux_diff,
  output logic [1:0] gain_code,
  output logic [10:0] gain_factor_lo,
  output logic [10:0] gain_factor_hi,
  // interrupt lines irq2..irq7
  output logic [5:0] irq_lines
);
  import adcac_pkg::*;

  typedef struct packed {
    logic jmp_s1;
    logic jmp_s2;
    logic done_s1;
    logic done_s2;
    logic done_d;
    logic [1:0] gain;
    logic [7:0] chan;
    logic [7:0] mode;
    logic [15:0] dout;
    logic [11:0] result;
    logic ready_n;
    logic int_flag;
    logic trig;
    logic [7:0] rdata;
    logic [3:0] mux;
    logic diff;
    logic [5:0] irq;
    logic [10:0] glo;
    logic [10:0] ghi;
  } adcac_state_type;

  adcac_state_type s_r;
  adcac_state_type s_nxt;
  logic pacer_tick;
  logic [2:0] mode_f;
  logic [2:0] irq_f;
  logic sw_en;
  logic pacer_en;
  logic poll_en;
  logic int_en;
  logic done_pulse;

  adcac_pacer u_pacer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load_lo(bus.wr && bus.addr == ADCAC_OFF_CNT1),
    .load_hi(bus.wr && bus.addr == ADCAC_OFF_CNT2),
    .load_data(bus.wdata),
    .run(pacer_en),
    .tick(pacer_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    mode_f = s_r.mode[ADCAC_MODE_LSB +: 3];
    irq_f = s_r.mode[ADCAC_IRQ_LSB +: 3];
    sw_en = (mode_f == ADCAC_MODE_SW0) || (mode_f == ADCAC_MODE_SW1);
    pacer_en = (mode_f == ADCAC_MODE_PACER) || (mode_f == ADCAC_MODE_PACER_INT);
    poll_en = sw_en || (mode_f == ADCAC_MODE_PACER_INT);
    int_en = (mode_f == ADCAC_MODE_PACER_INT);
    done_pulse = s_r.done_s2 && !s_r.done_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.jmp_s1 = input_type_jumper;
    s_nxt.jmp_s2 = s_r.jmp_s1;
    s_nxt.done_s1 = adc_done;
    s_nxt.done_s2 = s_r.done_s1;
    s_nxt.done_d = s_r.done_s2;
    s_nxt.trig = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        ADCAC_OFF_GAIN: s_nxt.gain = bus.wdata[1:0];
        ADCAC_OFF_CHAN: s_nxt.chan = bus.wdata;
        ADCAC_OFF_MODE: s_nxt.mode = bus.wdata;
        ADCAC_OFF_DO_LO: s_nxt.dout[7:0] = bus.wdata;
        ADCAC_OFF_DO_HI: s_nxt.dout[15:8] = bus.wdata;
        default: s_nxt.gain = s_r.gain;
      endcase
    end
    if (bus.wr && bus.addr == ADCAC_OFF_STROBE && sw_en) begin
      s_nxt.trig = 1'b1;
      s_nxt.ready_n = 1'b1;
    end
    if (pacer_en && pacer_tick) begin
      s_nxt.trig = 1'b1;
      s_nxt.ready_n = 1'b1;
    end
    if (bus.wr && bus.addr == ADCAC_OFF_INT_CLR) begin
      s_nxt.int_flag = 1'b0;
    end
    if (done_pulse) begin
      s_nxt.result = adc_result;
      s_nxt.ready_n = 1'b0;
      if (int_en) begin
        s_nxt.int_flag = 1'b1;
      end
    end
    // channel mux and gain outputs
    s_nxt.diff = s_r.jmp_s2;
    if (s_r.jmp_s2) begin
      s_nxt.mux = {1'b0, s_r.chan[2:0]};
    end else begin
      s_nxt.mux = s_r.chan[3:0];
    end
    s_nxt.glo = ADCAC_GAIN_LO[s_r.gain];
    s_nxt.ghi = ADCAC_GAIN_HI[s_r.gain];
    // interrupt routing
    s_nxt.irq = '0;
    if (s_r.int_flag && int_en) begin
      if (irq_f < ADCAC_IRQ_BASE) begin
        s_nxt.irq[0] = (irq_f != ADCAC_IRQ_UNUSED);
      end else begin
        s_nxt.irq[irq_f - 3'(ADCAC_IRQ_LINES - 4)] = 1'b1;
      end
    end
    // read data
    s_nxt.rdata = ADCAC_BYTE_RST;
    if (bus.rd) begin
      if (bus.addr == ADCAC_OFF_DATA_LO) begin
        s_nxt.rdata = s_r.result[7:0];
      end else if (bus.addr == ADCAC_OFF_DATA_HI) begin
        s_nxt.rdata = {4'h0, s_r.result[11:8]} |
                      (s_r.ready_n ? ADCAC_RDY_BIT : ADCAC_BYTE_RST);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.ready_n <= 1'b1;
      s_r.glo <= ADCAC_GAIN_LO[0];
      s_r.ghi <= ADCAC_GAIN_HI[0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_out = '{rdata: s_r.rdata, dout: s_r.dout};
  assign adc_trigger = s_r.trig;
  assign mux_sel = s_r.mux;
  assign mux_diff = s_r.diff;
  assign gain_code = s_r.gain;
  assign gain_factor_lo = s_r.glo;
  assign gain_factor_hi = s_r.ghi;
  assign irq_lines = s_r.irq;

endmodule // adcac_top

// file: verification/adcac_properties.sv
module adcac_properties
  import adcac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched ports
  input wire adcac_pkg::adcac_bus_type bus,
  input wire adcac_pkg::adcac_host_out_type host_out,
  input wire logic adc_trigger,
  input wire logic [3:0] mux_sel,
  input wire logic mux_diff,
  input wire logic [5:0] irq_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  import adcac_pkg::*;
  logic [2:0] mode_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) mode_r <= 3'h0;
    else if (bus.wr && bus.addr == ADCAC_OFF_MODE) mode_r <= bus.wdata[2:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence wr_to(logic [3:0] a);
    bus.wr && bus.addr == a;
  endsequence
  a_strobe_fires: assert property (
    wr_to(ADCAC_OFF_STROBE) ##0 mode_r[2:1] == 2'h0 |=> adc_trigger)
    else $error("strobe lost");
  a_strobe_dropped: assert property (
    wr_to(ADCAC_OFF_STROBE) ##0 !(mode_r inside {3'h0, 3'h1, 3'h2, 3'h6}) |=> !adc_trigger)
    else $error("strobe not refused");
  a_do_low: assert property (
    wr_to(ADCAC_OFF_DO_LO) |=> host_out.dout == {$past(host_out.dout[15:8]), $past(bus.wdata)})
    else $error("low output byte wrong");
  a_do_high: assert property (
    wr_to(ADCAC_OFF_DO_HI) |=> host_out.dout == {$past(bus.wdata), $past(host_out.dout[7:0])})
    else $error("high output byte wrong");
  a_chan_single: assert property (
    wr_to(ADCAC_OFF_CHAN) ##2 !mux_diff |-> mux_sel == $past(bus.wdata[3:0], 2))
    else $error("single channel wrong");
  a_chan_diff: assert property (
    wr_to(ADCAC_OFF_CHAN) ##2 mux_diff |-> mux_sel[2:0] == $past(bus.wdata[2:0], 2))
    else $error("pair channel wrong");
  a_irq_mode: assert property (
    mode_r != ADCAC_MODE_PACER_INT && $stable(mode_r) |-> irq_lines == 6'h00)
    else $error("irq outside interrupt mode");
  a_ready_fmt: assert property (
    $past(bus.rd) && $past(bus.addr) == ADCAC_OFF_DATA_HI |-> host_out.rdata[7:5] == 3'h0)
    else $error("high data byte format");
endmodule // adcac_properties
////////////////////////////////////////////////////////////////////////////////
bind adcac_top adcac_properties u_props (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
  .host_out(host_out), .adc_trigger(adc_trigger), .mux_sel(mux_sel), .mux_diff(mux_diff),
  .irq_lines(irq_lines));

// file: verification/adcac_host_model.sv
module adcac_host_model
  import adcac_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // host bus
  output adcac_pkg::adcac_bus_type bus,
  input wire adcac_pkg::adcac_host_out_type host_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus = '{1'b0, 1'b0, 4'hF, 8'hA5};
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge sys_clk);
    bus = '{w, ~w, a, d};
    @(negedge sys_clk);
    bus = '{1'b0, 1'b0, ~a, ~d};
    q = host_out.rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic poll(output logic [7:0] q);
    q = 8'hFF;
    for (int i = 0; i < 64 && q[4] !== 1'b0; i++) rd(ADCAC_OFF_DATA_HI, q);
  endtask
endmodule // adcac_host_model

// file: verification/test_adc_acquisition_control.sv
module test_adc_acquisition_control
  import adcac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, nrst = 1'b0, input_type_jumper = 1'b0, adc_done = 1'b0;
  logic adc_trigger, mux_diff;
  logic [11:0] adc_result = 12'h000, exp_r = 12'h000;
  logic [3:0] mux_sel;
  logic [1:0] gain_code;
  logic [10:0] gain_factor_lo, gain_factor_hi;
  logic [5:0] irq_lines;
  adcac_bus_type bus;
  adcac_host_out_type host_out;
  int n_errors = 0, samples_checked = 0, seed = 32'h4C8B, cyc = 0, cnt = 0, n_trig = 0;
  always #12.5 sys_clk = ~sys_clk;
  adcac_top u_adcac_top (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .host_out(host_out),
    .input_type_jumper(input_type_jumper), .adc_done(adc_done), .adc_result(adc_result),
    .adc_trigger(adc_trigger), .mux_sel(mux_sel), .mux_diff(mux_diff), .gain_code(gain_code),
    .gain_factor_lo(gain_factor_lo), .gain_factor_hi(gain_factor_hi), .irq_lines(irq_lines));
  adcac_host_model u_host (.sys_clk(sys_clk), .bus(bus), .host_out(host_out));
  // converter answers each trigger
  always @(negedge sys_clk) begin
    n_trig += int'(adc_trigger);
    if (adc_trigger) exp_r = 12'($random(seed));
    cnt = adc_trigger ? 8 : (cnt > 0) ? cnt - 1 : 0;
    adc_done = cnt inside {[1:3]};
    adc_result = (cnt > 0) ? exp_r : ~adc_result;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic ck(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // settling wait in clock cycles per gain code, 40 cycles per microsecond
  function automatic int settle_cyc(input logic [1:0] g);
    return 40 * ((g == 2'h3) ? 28 : (g == 2'h2) ? 25 : 23);
  endfunction
  function automatic logic [5:0] irq_exp(input logic [2:0] k);
    return (k == 3'h1) ? 6'h00 : (k < 3'h3) ? 6'h01 : 6'h01 << (k - 3'h2);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r, q;
    logic [15:0] dex;
    int n0;
    dex = 16'h0000;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    ck("dout", 16'h0000, host_out.dout);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      r = (i == 0) ? 8'hFF : 8'($random(seed));
      input_type_jumper = r[7];
      u_host.wr(ADCAC_OFF_GAIN, r);
      u_host.wr(i[0] ? ADCAC_OFF_DO_HI : ADCAC_OFF_DO_LO, r);
      if (i[0]) dex[15:8] = r;
      else dex[7:0] = r;
      ck("dout", dex, host_out.dout);
      u_host.wr(ADCAC_OFF_CHAN, r);
      @(negedge sys_clk);
      ck("gain code", 16'(r[1:0]), 16'(gain_code));
      ck("gain lo", 16'(ADCAC_GAIN_LO[r[1:0]]), 16'(gain_factor_lo));
      ck("gain hi", 16'(ADCAC_GAIN_HI[r[1:0]]), 16'(gain_factor_hi));
      ck("diff", 16'(r[7]), 16'(mux_diff));
      ck("mux", 16'(r[3:0] & {!r[7], 3'h7}), 16'(mux_sel & {!r[7], 3'h7}));
    end
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      u_host.wr(ADCAC_OFF_MODE, 8'(m % 2));
      u_host.wr(ADCAC_OFF_CHAN, 8'($random(seed)));
      u_host.wr(ADCAC_OFF_GAIN, 8'(m));
      repeat (settle_cyc(2'(m))) @(negedge sys_clk);
      u_host.wr(ADCAC_OFF_STROBE, 8'(m * 85));
      u_host.rd(ADCAC_OFF_DATA_HI, q);
      ck("busy", 16'h0010, 16'(q & 8'h10));
      u_host.poll(q);
      ck("hi", 16'(exp_r[11:8]), 16'(q));
      u_host.rd(ADCAC_OFF_DATA_LO, q);
      ck("lo", 16'(exp_r[7:0]), 16'(q));
    end
    $display("polled test done");
    for (int m = 3; m < 8; m++) if (m != 6) begin
      u_host.wr(ADCAC_OFF_MODE, 8'(m));
      n0 = n_trig;
      u_host.wr(ADCAC_OFF_STROBE, 8'hFF);
      repeat (4) @(negedge sys_clk);
      ck("refused", 16'(n0), 16'(n_trig));
    end
    $display("refusal test done");
    u_host.wr(ADCAC_OFF_CNT1, 8'h00);
    u_host.wr(ADCAC_OFF_CNT1, 8'h04);
    u_host.wr(ADCAC_OFF_CNT2, 8'h00);
    u_host.wr(ADCAC_OFF_CNT2, 8'h10);
    for (int k = 0; k < 9; k++) begin
      u_host.wr(ADCAC_OFF_MODE, (k < 8) ? {1'b0, 3'(k), 4'h6} : 8'h32);
      repeat (70) @(negedge sys_clk);
      #1;
      n0 = n_trig;
      repeat (256) @(negedge sys_clk);
      #1;
      ck("ticks", 16'h0004, 16'(n_trig - n0));
      for (int j = 0; j < 80 && adc_trigger !== 1'b1; j++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      ck("irq", 16'((k < 8) ? irq_exp(3'(k)) : 6'h00), 16'(irq_lines));
      u_host.wr(ADCAC_OFF_INT_CLR, 8'h5A);
      @(negedge sys_clk);
      ck("irq clr", 16'h0000, 16'(irq_lines));
    end
    $display("pacer test done");
    give_verdict();
  end
endmodule // test_adc_acquisition_control
